// ===== rtl/mcu_rotate_sub_skip_exec.sv
// execution block for rotate, subtract, skip, set, swap, table read and xor
// assumes an Avalon-MM master; software writes an instruction word to launch it
`default_nettype none

module mcu_rotate_sub_skip_exec (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // avalon-mm slave
  input  wire logic [rse_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest
);

  rse_pkg::exec_state_t              state;
  rse_pkg::exec_state_t              next_state;
  rse_pkg::bus_phase_t               phase;
  rse_pkg::instr_t                   instr;
  rse_pkg::flags_t                   flags;
  rse_pkg::flags_t                   next_flags;
  rse_pkg::flags_t                   subRes;
  logic [7:0]                        acc;
  logic [7:0]                        next_acc;
  logic [rse_pkg::TPTR_W-1:0]        tablePtr;
  logic [7:0]                        tableHigh;
  logic [7:0]                        next_tableHigh;
  logic [rse_pkg::PAGE_W-1:0]        page;
  logic                              lastSkip;
  logic                              skipNow;
  logic                              execMemWe;
  logic [7:0]                        execMemWd;

  // bus decode
  logic                              busReq;
  logic                              busDone;
  logic                              busWr;
  logic                              idle;
  logic                              selDmem;
  logic                              selPmem;
  logic                              launch;
  logic [31:0]                       regRead;
  logic [31:0]                       readMux;

  // memories
  logic                              dmemWe;
  logic [rse_pkg::DMEM_AW-1:0]       dmemAddr;
  logic [7:0]                        dmemWdata;
  logic [7:0]                        dmemRdata;
  logic                              pmemWe;
  logic [rse_pkg::PMEM_AW-1:0]       pmemAddr;
  logic [rse_pkg::PWORD_W-1:0]       pmemRdata;
  logic [rse_pkg::PAGE_W-1:0]        tablePage;

  // alu operands
  logic [7:0]                        m;
  logic [7:0]                        opB;
  logic                              subCin;
  logic [7:0]                        subDiff;
  logic [7:0]                        decM;
  logic [7:0]                        incM;
  logic [7:0]                        bitMask;
  logic [7:0]                        xorRes;
  logic                              isImm;
  logic                              isBorrow;

  assign idle    = (state == rse_pkg::ST_IDLE);
  assign busReq  = avs_read | avs_write;
  assign busDone = busReq & (phase == rse_pkg::PH_DONE);
  // byte lane 0 enables every write; writes without it are dropped
  assign busWr   = busDone & avs_write & avs_byteenable[0];
  assign selDmem = (avs_address[12:10] == rse_pkg::DMEM_TAG);
  assign selPmem = (avs_address[12:12] == rse_pkg::PMEM_TAG);
  assign launch  = busWr & (avs_address == rse_pkg::OFS_EXEC);
  // a request waits out any running instruction, then two cycles
  assign avs_waitrequest = busReq & (phase != rse_pkg::PH_DONE);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= rse_pkg::PH_IDLE;
    end else begin
      case (phase)
        rse_pkg::PH_IDLE: phase <= (busReq & idle) ? rse_pkg::PH_DATA : rse_pkg::PH_IDLE;
        rse_pkg::PH_DATA: phase <= rse_pkg::PH_DONE;
        default:          phase <= rse_pkg::PH_IDLE;
      endcase
    end
  end

  assign regRead =
    (avs_address == rse_pkg::OFS_EXEC)   ? instr :
    (avs_address == rse_pkg::OFS_ACC)    ? {24'h000000, acc} :
    (avs_address == rse_pkg::OFS_STATUS) ? {26'h0000000, ~idle, lastSkip, flags} :
    (avs_address == rse_pkg::OFS_TPTR)   ? {24'h000000, tablePtr} :
    (avs_address == rse_pkg::OFS_THIGH)  ? {24'h000000, tableHigh} :
    (avs_address == rse_pkg::OFS_PAGE)   ? {30'h00000000, page} : 32'h0000_0000;
  assign readMux = selPmem ? {16'h0000, pmemRdata} :
                   selDmem ? {24'h000000, dmemRdata} : regRead;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (phase == rse_pkg::PH_DATA && avs_read) begin
      avs_readdata <= readMux;
    end
  end

  // bus owns the memories while idle; fetch and dummy see stale operands, so never write
  assign tablePage = (instr.op == rse_pkg::OP_TABLE_FETCH_LAST_PAGE) ? rse_pkg::LAST_PAGE : page;
  assign dmemAddr  = idle ? avs_address[9:2] : instr.memAddr;
  assign dmemWe    = idle ? (busWr & selDmem) : (execMemWe & (state == rse_pkg::ST_EXEC));
  assign dmemWdata = idle ? avs_writedata[7:0] : execMemWd;
  assign pmemAddr  = idle ? avs_address[11:2] : {tablePage, tablePtr};
  assign pmemWe    = idle & busWr & selPmem;

  mem_block #(.W (8), .AW (rse_pkg::DMEM_AW)) u_dmem (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .we       (dmemWe),
    .addr     (dmemAddr),
    .wdata    (dmemWdata),
    .rdata    (dmemRdata)
  );

  mem_block #(.W (rse_pkg::PWORD_W), .AW (rse_pkg::PMEM_AW)) u_pmem (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .we       (pmemWe),
    .addr     (pmemAddr),
    .wdata    (avs_writedata[15:0]),
    .rdata    (pmemRdata)
  );

  // alu
  assign m        = dmemRdata;
  assign isImm    = (instr.op == rse_pkg::OP_MINUS_IMM) | (instr.op == rse_pkg::OP_EXCL_OR_IMM);
  assign isBorrow = (instr.op == rse_pkg::OP_MINUS_BORROW_ACC) |
                    (instr.op == rse_pkg::OP_MINUS_BORROW_TO_MEM);
  assign opB      = isImm ? instr.literal : m;
  assign subCin   = isBorrow ? flags.carry : 1'b1;
  assign decM     = m - rse_pkg::BYTE_ONE;
  assign incM     = m + rse_pkg::BYTE_ONE;
  assign bitMask  = rse_pkg::BYTE_ONE << instr.bitSel;
  assign xorRes   = acc ^ opB;

  sub_flags u_sub (
    .a     (acc),
    .b     (opB),
    .cin   (subCin),
    .diff  (subDiff),
    .flags (subRes)
  );

  always_comb begin
    next_acc  = acc;
    next_flags = flags;
    next_tableHigh = tableHigh;
    execMemWe = 1'b0;
    execMemWd = m;
    skipNow   = 1'b0;
    case (instr.op)
      rse_pkg::OP_ROTL_TO_ACC: next_acc = {m[6:0], m[7]};
      rse_pkg::OP_ROTL_VIA_CY: begin
        execMemWe = 1'b1;
        execMemWd = {m[6:0], flags.carry};
        next_flags.carry = m[7];
      end
      rse_pkg::OP_ROTL_VIA_CY_TO_ACC: begin
        next_acc = {m[6:0], flags.carry};
        next_flags.carry = m[7];
      end
      rse_pkg::OP_ROTATE_RIGHT_MEM: begin
        execMemWe = 1'b1;
        execMemWd = {m[0], m[7:1]};
      end
      rse_pkg::OP_ROTATE_RIGHT_TO_ACC: next_acc = {m[0], m[7:1]};
      rse_pkg::OP_ROTATE_RIGHT_VIA_CY: begin
        execMemWe = 1'b1;
        execMemWd = {flags.carry, m[7:1]};
        next_flags.carry = m[0];
      end
      rse_pkg::OP_ROTATE_RIGHT_VIA_CY_TO_ACC: begin
        next_acc = {flags.carry, m[7:1]};
        next_flags.carry = m[0];
      end
      rse_pkg::OP_MINUS_BORROW_ACC, rse_pkg::OP_MINUS_ACC, rse_pkg::OP_MINUS_IMM: begin
        next_acc   = subDiff;
        next_flags = subRes;
      end
      rse_pkg::OP_MINUS_BORROW_TO_MEM, rse_pkg::OP_MINUS_TO_MEM: begin
        execMemWe  = 1'b1;
        execMemWd  = subDiff;
        next_flags = subRes;
      end
      rse_pkg::OP_DEC_SKIP_ZERO: begin
        execMemWe = 1'b1;
        execMemWd = decM;
        skipNow   = (decM == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_DEC_SKIP_ZERO_TO_ACC: begin
        next_acc = decM;
        skipNow  = (decM == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_INC_SKIP_ZERO: begin
        execMemWe = 1'b1;
        execMemWd = incM;
        skipNow   = (incM == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_INC_SKIP_ZERO_TO_ACC: begin
        next_acc = incM;
        skipNow  = (incM == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_SET_BYTE: begin
        execMemWe = 1'b1;
        execMemWd = rse_pkg::BYTE_ONES;
      end
      rse_pkg::OP_SET_BIT: begin
        execMemWe = 1'b1;
        execMemWd = m | bitMask;
      end
      rse_pkg::OP_SKIP_BIT_ONE: skipNow = |(m & bitMask);
      rse_pkg::OP_SKIP_BIT_ZERO: skipNow = ~|(m & bitMask);
      rse_pkg::OP_SKIP_MEM_ZERO: skipNow = (m == rse_pkg::BYTE_ZERO);
      rse_pkg::OP_SKIP_ZERO_COPY_ACC: begin
        next_acc = m;
        skipNow  = (m == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_NIBBLE_EXCHANGE_MEM: begin
        execMemWe = 1'b1;
        execMemWd = {m[3:0], m[7:4]};
      end
      rse_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: next_acc = {m[3:0], m[7:4]};
      rse_pkg::OP_TABLE_FETCH_CUR_PAGE, rse_pkg::OP_TABLE_FETCH_LAST_PAGE: begin
        execMemWe = 1'b1;
        execMemWd = pmemRdata[7:0];
        next_tableHigh = pmemRdata[15:8];
      end
      rse_pkg::OP_EXCL_OR_ACC, rse_pkg::OP_EXCL_OR_IMM: begin
        next_acc        = xorRes;
        next_flags.zero = (xorRes == rse_pkg::BYTE_ZERO);
      end
      rse_pkg::OP_EXCLUSIVE_OR_TO_MEM: begin
        execMemWe       = 1'b1;
        execMemWd       = xorRes;
        next_flags.zero = (xorRes == rse_pkg::BYTE_ZERO);
      end
      default: next_acc = acc;
    endcase
  end

  // a taken skip costs one dummy cycle before the return to idle
  always_comb begin
    case (state)
      rse_pkg::ST_IDLE:  next_state = launch ? rse_pkg::ST_FETCH : rse_pkg::ST_IDLE;
      rse_pkg::ST_FETCH: next_state = rse_pkg::ST_EXEC;
      rse_pkg::ST_EXEC:  next_state = skipNow ? rse_pkg::ST_DUMMY : rse_pkg::ST_IDLE;
      default:           next_state = rse_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= rse_pkg::ST_IDLE;
      instr    <= rse_pkg::INSTR_RST;
      lastSkip <= 1'b0;
    end else begin
      state <= next_state;
      if (launch) begin
        instr <= avs_writedata;
      end
      if (state == rse_pkg::ST_EXEC) begin
        lastSkip <= skipNow;
      end
    end
  end

  // bus writes land only while idle, so they never race the alu
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc   <= rse_pkg::BYTE_ZERO;
      flags <= rse_pkg::FLAGS_RST;
      tableHigh <= rse_pkg::BYTE_ZERO;
      tablePtr  <= rse_pkg::BYTE_ZERO;
      page  <= rse_pkg::PAGE_RST;
    end else if (state == rse_pkg::ST_EXEC) begin
      acc   <= next_acc;
      flags <= next_flags;
      tableHigh <= next_tableHigh;
    end else if (busWr) begin
      if (avs_address == rse_pkg::OFS_ACC)    acc   <= avs_writedata[7:0];
      if (avs_address == rse_pkg::OFS_STATUS) flags <= avs_writedata[3:0];
      if (avs_address == rse_pkg::OFS_TPTR)   tablePtr <= avs_writedata[7:0];
      if (avs_address == rse_pkg::OFS_PAGE)   page  <= avs_writedata[1:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_ROTL_CY_MEM: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_ROTL_VIA_CY)
      |-> dmemWe && dmemWdata == {dmemRdata[6:0], flags.carry}
      ##1 flags.carry == $past(dmemRdata[7]) && acc == $past(acc))
    else $error("rotate left through carry wrong");

  AST_ROTL_CY_ACC: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_ROTL_VIA_CY_TO_ACC)
      |-> !dmemWe ##1 acc == {$past(dmemRdata[6:0]), $past(flags.carry)})
    else $error("rotate left through carry to acc wrong");

  AST_ROTL_ACC: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_ROTL_TO_ACC)
      |=> acc == {$past(dmemRdata[6:0]), $past(dmemRdata[7])} && $stable(flags))
    else $error("rotate left to acc wrong");

  AST_ROTR_MEM: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_ROTATE_RIGHT_MEM)
      |-> dmemWe && dmemWdata == {dmemRdata[0], dmemRdata[7:1]} ##1 $stable(flags))
    else $error("rotate right memory wrong");

  AST_ROTR_CY_ACC: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_ROTATE_RIGHT_VIA_CY_TO_ACC)
      |=> acc == {$past(flags.carry), $past(dmemRdata[7:1])}
          && flags.carry == $past(dmemRdata[0]))
    else $error("rotate right through carry to acc wrong");

  AST_MINUS_BORROW_RESULT: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_MINUS_BORROW_ACC)
      |=> acc == 8'($past(acc) - $past(dmemRdata) - {7'h00, ~$past(flags.carry)}))
    else $error("subtract with borrow result wrong");

  AST_SUB_CARRY: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_MINUS_ACC)
      |=> flags.carry == ($past(acc) >= $past(dmemRdata))
          && flags.zero == ($past(acc) == $past(dmemRdata)))
    else $error("subtract carry or zero wrong");

  AST_SKIP_DUMMY: assert property (
    (state == rse_pkg::ST_EXEC && skipNow)
      |=> state == rse_pkg::ST_DUMMY ##1 state == rse_pkg::ST_IDLE && lastSkip)
    else $error("taken skip did not last two cycles");

  AST_DEC_SKIP: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_DEC_SKIP_ZERO)
      |-> skipNow == (dmemRdata == rse_pkg::BYTE_ONE) ##1 $stable(flags))
    else $error("decrement skip wrong");

  AST_SET_BYTE: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_SET_BYTE)
      |-> dmemWe && dmemWdata == rse_pkg::BYTE_ONES)
    else $error("set byte wrong");

  AST_XOR_ZERO: assert property (
    (state == rse_pkg::ST_EXEC && instr.op == rse_pkg::OP_EXCL_OR_ACC)
      |=> flags.zero == ($past(acc) == $past(dmemRdata))
          && flags.carry == $past(flags.carry))
    else $error("xor zero flag wrong");

  AST_DUMMY_FLAGS: assert property (
    (state == rse_pkg::ST_DUMMY) |=> $stable(flags) && $stable(acc))
    else $error("state changed in dummy cycle");

endmodule // mcu_rotate_sub_skip_exec

`default_nettype wire

// ===== rtl/mem_block.sv
// synchronous single-port memory with registered read data
// assumes one writer at a time; read data follow the address one cycle later
`default_nettype none

module mem_block #(
  parameter int W  = 8,
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] store [2**AW];

  always_ff @(posedge core_clk) begin
    if (we) begin
      store[addr] <= wdata;
    end
  end

  // read-before-write: a write shows on the next read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= store[addr];
    end
  end

endmodule // mem_block

`default_nettype wire

// ===== rtl/rse_pkg.sv
// constants, field layouts and types for the rotate/subtract/skip execution block
// assumes one core clock and an Avalon-MM slave port with byte addresses
//
// Operation
// - rotate memory left through carry, carry only
// - same into accumulator, memory left alone
// - rotate left into accumulator, no flags
// - rotate memory right in place, no flags
// - rotate right into accumulator, no flags
// - rotate memory right through carry, carry only
// - same into accumulator, memory left alone
// - accumulator minus memory minus inverted carry
// - memory-destination subtracts write difference to memory
// - plain subtract, carry set when not negative
// - subtract literal from accumulator, same flags
// - decrement, skip on zero, no flags
// - increment, skip on zero, no flags
// - taken skip adds one dummy cycle
// - set byte to ones or one bit
// - skip on chosen bit set or clear
// - skip on zero byte, optional accumulator copy
// - swap nibbles in place or into accumulator
// - table read from current page, split word
// - table read from last page, split word
// - xor into accumulator, zero flag only
// - xor into memory, zero flag only
`default_nettype none

package rse_pkg;

  localparam int ADDR_W = 13;
  localparam int DMEM_AW = 8;
  localparam int PMEM_AW = 10;
  localparam int PAGE_W = 2;
  localparam int TPTR_W = 8;
  localparam int PWORD_W = 16;

  // register byte offsets
  localparam logic [12:0] OFS_EXEC   = 13'h0000;
  localparam logic [12:0] OFS_ACC    = 13'h0004;
  localparam logic [12:0] OFS_STATUS = 13'h0008;
  localparam logic [12:0] OFS_TPTR   = 13'h000C;
  localparam logic [12:0] OFS_THIGH  = 13'h0010;
  localparam logic [12:0] OFS_PAGE   = 13'h0014;
  // data memory window 0x0400..0x07FC, program memory window 0x1000..0x1FFC
  localparam logic [2:0]  DMEM_TAG   = 3'h1;
  localparam logic [0:0]  PMEM_TAG   = 1'h1;

  // status bit positions
  localparam int ST_SKIP = 4;
  localparam int ST_BUSY = 5;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [7:0]  BYTE_ONES = 8'hFF;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;
  localparam logic [PAGE_W-1:0] PAGE_RST  = 2'h0;

  typedef enum logic [4:0] {
    OP_NOP                        = 5'h00,
    OP_ROTL_TO_ACC                = 5'h01,
    OP_ROTL_VIA_CY                = 5'h02,
    OP_ROTL_VIA_CY_TO_ACC         = 5'h03,
    OP_ROTATE_RIGHT_MEM           = 5'h04,
    OP_ROTATE_RIGHT_TO_ACC        = 5'h05,
    OP_ROTATE_RIGHT_VIA_CY        = 5'h06,
    OP_ROTATE_RIGHT_VIA_CY_TO_ACC = 5'h07,
    OP_MINUS_BORROW_ACC           = 5'h08,
    OP_MINUS_BORROW_TO_MEM        = 5'h09,
    OP_MINUS_ACC                  = 5'h0A,
    OP_MINUS_TO_MEM               = 5'h0B,
    OP_MINUS_IMM                  = 5'h0C,
    OP_DEC_SKIP_ZERO              = 5'h0D,
    OP_DEC_SKIP_ZERO_TO_ACC       = 5'h0E,
    OP_INC_SKIP_ZERO              = 5'h0F,
    OP_INC_SKIP_ZERO_TO_ACC       = 5'h10,
    OP_SET_BYTE                   = 5'h11,
    OP_SET_BIT                    = 5'h12,
    OP_SKIP_BIT_ONE               = 5'h13,
    OP_SKIP_BIT_ZERO              = 5'h14,
    OP_SKIP_MEM_ZERO              = 5'h15,
    OP_SKIP_ZERO_COPY_ACC         = 5'h16,
    OP_NIBBLE_EXCHANGE_MEM        = 5'h17,
    OP_NIBBLE_EXCHANGE_TO_ACC     = 5'h18,
    OP_TABLE_FETCH_CUR_PAGE       = 5'h19,
    OP_TABLE_FETCH_LAST_PAGE      = 5'h1A,
    OP_EXCL_OR_ACC                = 5'h1B,
    OP_EXCL_OR_IMM                = 5'h1C,
    OP_EXCLUSIVE_OR_TO_MEM        = 5'h1D
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10,
    ST_DUMMY = 2'b11
  } exec_state_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic signedExcess;
    logic zero;
    logic halfCarry;
    logic carry;
  } flags_t;

  localparam flags_t FLAGS_RST = 4'h0;

  typedef struct packed {
    logic [7:0] literal;
    logic [7:0] memAddr;
    logic [4:0] rsvHi;
    logic [2:0] bitSel;
    logic [2:0] rsvLo;
    op_t        op;
  } instr_t;

  localparam instr_t INSTR_RST = 32'h0000_0000;

endpackage

`default_nettype wire

// ===== rtl/sub_flags.sv
// 8-bit subtractor a - b - ~cin with carry, half carry, zero and overflow
// assumes carry means no borrow
`default_nettype none

module sub_flags (
  // operands
  input  wire logic         [7:0] a,
  input  wire logic         [7:0] b,
  input  wire logic               cin,
  // result
  output logic            [7:0]   diff,
  output rse_pkg::flags_t         flags
);

  logic [8:0] full;
  logic [4:0] half;

  assign full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
  assign half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign diff = full[7:0];
  assign flags.carry        = full[8];
  assign flags.halfCarry    = half[4];
  assign flags.zero         = (full[7:0] == rse_pkg::BYTE_ZERO);
  // signs differ and result sign leaves the minuend's
  assign flags.signedExcess = (a[7] ^ b[7]) & (full[7] ^ a[7]);

endmodule // sub_flags

`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the rotate/subtract/skip execution block
// assumes the block alone on its Avalon-MM port, driven from here
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk        = 1'b0;
  logic        sys_rst         = 1'b1;
  logic [12:0] avs_address     = 13'h0000;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] q;
  int          n_fail          = 0;
  int          checks_done     = 0;
  int          latBus;
  int          latExec;
  int          latSkip;

  mcu_rotate_sub_skip_exec mcu_rotate_sub_skip_exec_i (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (4'hF),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    // request stands until an edge sees waitrequest low; that edge takes the data
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 60);
    q = avs_readdata;
    latBus = n;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 60) begin
      check(32'h0, 32'h1);
      final_report();
    end
  endtask

  // load operand, acc and flags, launch, then read back flags, operand and acc
  task automatic one(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] lit, m, a,
                     input logic [5:0] st, input logic [7:0] em, ea, input logic [5:0] est);
    bus(1'b1, 13'h0414, {24'h0, m});
    bus(1'b1, rse_pkg::OFS_ACC, {24'h0, a});
    bus(1'b1, rse_pkg::OFS_STATUS, {26'h0, st});
    bus(1'b1, rse_pkg::OFS_EXEC, {lit, 8'h05, 5'h00, bs, 3'h0, op});
    bus(1'b0, rse_pkg::OFS_STATUS, 32'h0);
    latExec = latBus;
    check({26'h0, q[5:0]}, {26'h0, est});
    bus(1'b0, 13'h0414, 32'h0);
    check({24'h0, q[7:0]}, {24'h0, em});
    bus(1'b0, rse_pkg::OFS_ACC, 32'h0);
    check({24'h0, q[7:0]}, {24'h0, ea});
  endtask

  task automatic t_reset;
    logic [12:0] a [4] = '{rse_pkg::OFS_ACC, rse_pkg::OFS_STATUS, rse_pkg::OFS_THIGH, 13'h0200};
    bus(1'b1, 13'h0200, 32'h5A);
    foreach (a[i]) begin
      bus(1'b0, a[i], 32'h0);
      check(q, 32'h0);
    end
  endtask

  task automatic t_rotate;
    one(5'h02,3'h0,8'h00,8'h96,8'h33,6'h0E,8'h2C,8'h33,6'h0F);
    one(5'h03,3'h0,8'h00,8'h96,8'h33,6'h00,8'h96,8'h2C,6'h01);
    one(5'h01,3'h0,8'h00,8'h96,8'h33,6'h05,8'h96,8'h2D,6'h05);
    one(5'h04,3'h0,8'h00,8'h96,8'h33,6'h0A,8'h4B,8'h33,6'h0A);
    one(5'h05,3'h0,8'h00,8'h97,8'h33,6'h01,8'h97,8'hCB,6'h01);
    one(5'h06,3'h0,8'h00,8'h96,8'h33,6'h0F,8'hCB,8'h33,6'h0E);
    one(5'h07,3'h0,8'h00,8'h97,8'h33,6'h00,8'h97,8'h4B,6'h01);
  endtask

  task automatic t_sub;
    one(5'h08,3'h0,8'h00,8'h10,8'h10,6'h04,8'h10,8'hFF,6'h00);
    one(5'h08,3'h0,8'h00,8'h10,8'h10,6'h09,8'h10,8'h00,6'h07);
    one(5'h09,3'h0,8'h00,8'h10,8'h10,6'h01,8'h00,8'h10,6'h07);
    one(5'h0B,3'h0,8'h00,8'h30,8'h50,6'h00,8'h20,8'h50,6'h03);
    one(5'h0A,3'h0,8'h00,8'h30,8'h50,6'h0C,8'h30,8'h20,6'h03);
    one(5'h0A,3'h0,8'h00,8'h01,8'h80,6'h00,8'h01,8'h7F,6'h09);
    one(5'h0C,3'h0,8'h06,8'h77,8'h05,6'h0F,8'h77,8'hFF,6'h00);
  endtask

  task automatic t_skip;
    one(5'h0D,3'h0,8'h00,8'h01,8'h33,6'h05,8'h00,8'h33,6'h15);
    latSkip = latExec;
    one(5'h0D,3'h0,8'h00,8'h05,8'h33,6'h05,8'h04,8'h33,6'h05);
    check(32'(latSkip - latExec), 32'h1);
    one(5'h0E,3'h0,8'h00,8'h01,8'h33,6'h05,8'h01,8'h00,6'h15);
    one(5'h0F,3'h0,8'h00,8'hFF,8'h33,6'h05,8'h00,8'h33,6'h15);
    one(5'h10,3'h0,8'h00,8'h7F,8'h33,6'h05,8'h7F,8'h80,6'h05);
    one(5'h13,3'h7,8'h00,8'h80,8'h33,6'h05,8'h80,8'h33,6'h15);
    one(5'h13,3'h7,8'h00,8'h7F,8'h33,6'h05,8'h7F,8'h33,6'h05);
    one(5'h14,3'h0,8'h00,8'hFE,8'h33,6'h05,8'hFE,8'h33,6'h15);
    one(5'h14,3'h0,8'h00,8'h01,8'h33,6'h05,8'h01,8'h33,6'h05);
    one(5'h15,3'h0,8'h00,8'h00,8'h33,6'h05,8'h00,8'h33,6'h15);
    one(5'h16,3'h0,8'h00,8'h42,8'h33,6'h05,8'h42,8'h42,6'h05);
    one(5'h16,3'h0,8'h00,8'h00,8'h33,6'h0A,8'h00,8'h00,6'h1A);
  endtask

  task automatic t_misc;
    one(5'h11,3'h0,8'h00,8'h12,8'h33,6'h0A,8'hFF,8'h33,6'h0A);
    one(5'h12,3'h3,8'h00,8'h00,8'h33,6'h05,8'h08,8'h33,6'h05);
    one(5'h17,3'h0,8'h00,8'h3C,8'h33,6'h05,8'hC3,8'h33,6'h05);
    one(5'h18,3'h0,8'h00,8'h3C,8'h33,6'h0A,8'h3C,8'hC3,6'h0A);
    one(5'h1B,3'h0,8'h00,8'h5A,8'h5A,6'h0B,8'h5A,8'h00,6'h0F);
    one(5'h1C,3'h0,8'hFF,8'h77,8'h0F,6'h04,8'h77,8'hF0,6'h00);
    one(5'h1D,3'h0,8'h00,8'hF0,8'h0F,6'h05,8'hFF,8'h0F,6'h01);
  endtask

  task automatic t_table;
    bus(1'b1, 13'h1488, 32'hA55A);
    bus(1'b1, 13'h1C88, 32'h1234);
    bus(1'b1, rse_pkg::OFS_TPTR, 32'h22);
    bus(1'b1, rse_pkg::OFS_PAGE, 32'h1);
    one(5'h19,3'h0,8'h00,8'h00,8'h33,6'h06,8'h5A,8'h33,6'h06);
    bus(1'b0, rse_pkg::OFS_THIGH, 32'h0);
    check({24'h0, q[7:0]}, 32'hA5);
    one(5'h1A,3'h0,8'h00,8'h00,8'h33,6'h09,8'h34,8'h33,6'h09);
    bus(1'b0, rse_pkg::OFS_THIGH, 32'h0);
    check({24'h0, q[7:0]}, 32'h12);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rotate();
    t_sub();
    t_skip();
    t_misc();
    t_table();
    final_report();
  end
endmodule // tb

`default_nettype wire
